// File: verilog/dscw_regs.vh
// constants for the drive state control word interpreter
// assumes inclusion by bare name from the design files
`ifndef DSCW_REGS_VH
`define DSCW_REGS_VH
// control word bit positions
`define DSCW_CW_SWITCH_ON     0
`define DSCW_CW_ENABLE_VOLT   1
`define DSCW_CW_QUICK_STOP_N  2
`define DSCW_CW_ENABLE_OP     3
`define DSCW_CW_FAULT_RESET   7
`define DSCW_CW_HALT          8
`define DSCW_CW_ASSIGN_LO     11
// status word bit positions
`define DSCW_SW_READY         0
`define DSCW_SW_SWITCHED_ON   1
`define DSCW_SW_OP_ENABLED    2
`define DSCW_SW_FAULT         3
`define DSCW_SW_VOLT_PRESENT  4
`define DSCW_SW_QUICK_STOP_N  5
`define DSCW_SW_ON_DISABLED   6
`define DSCW_SW_WARNING       7
`define DSCW_SW_REMOTE        9
`define DSCW_SW_REF_REACHED   10
`define DSCW_SW_REF_LIMIT     11
`define DSCW_SW_STOP_KEY      14
`define DSCW_SW_DIRECTION     15
`define DSCW_STATUS_RESET     16'h0000
// selector codes C311..C315: 0 means unassigned, 1..5 pick bit 11..15
`define DSCW_SEL_NONE         3'h0
`define DSCW_SEL_BIT11        3'h1
// supply wait timeout, ms, and cycles at 125 MHz
`define DSCW_CLK_MHZ          125
`define DSCW_SUPPLY_WAIT_MS   1000
`define DSCW_SUPPLY_WAIT_CYC  (`DSCW_SUPPLY_WAIT_MS * `DSCW_CLK_MHZ * 1000)
`endif

// File: verilog/dscw_bit_select.v
// picks the control word bit assigned to one drive function
// assumes a selector code from configuration: 0 none, 1..5 bits 11..15
`include "dscw_regs.vh"
module dscw_bit_select (
	input wire [15:0] ctrl_word,
	input wire [2:0]  sel,
	output reg        hit
);
	always @* begin
		case (sel)
			3'h1: hit = ctrl_word[11];
			3'h2: hit = ctrl_word[12];
			3'h3: hit = ctrl_word[13];
			3'h4: hit = ctrl_word[14];
			3'h5: hit = ctrl_word[15];
			default: hit = 1'b0;
		endcase
	end
endmodule

// File: verilog/dscw_core.v
// drive operating state machine: control word in, status word out
// assumes one control word per clock from the fieldbus side, inputs synchronous
`include "dscw_regs.vh"
module dscw_core #(
	parameter SUPPLY_WAIT_CYC = `DSCW_SUPPLY_WAIT_CYC,
	parameter WAIT_W          = 27
) (
	input wire        clk,
	input wire        rst_n,
	input wire [15:0] ctrl_word,
	input wire        init_done,
	input wire        supply_present,
	input wire        contactor_mode,
	input wire [2:0]  sel_fast_stop,
	input wire [2:0]  sel_freewheel,
	input wire [2:0]  sel_reverse,
	input wire        term_fast_stop,
	input wire        term_freewheel,
	input wire        fault_detect,
	input wire        fault_reaction_done,
	input wire        warning_active,
	input wire        fieldbus_source,
	input wire        ref_reached,
	input wire        ref_limit,
	input wire        stop_key,
	input wire        quick_stop_done,
	output reg [15:0] drive_state_report_word,
	output reg [3:0]  op_state,
	output reg        power_enable,
	output reg        motion_stop,
	output reg        reverse_dir,
	output reg        contactor_close,
	output reg        contactor_fault,
	output reg        supply_absent_display
);
	localparam ST_NOT_READY  = 4'h1;
	localparam ST_ON_DIS     = 4'h2;
	localparam ST_READY      = 4'h3;
	localparam ST_SWITCHED   = 4'h4;
	localparam ST_ENABLED    = 4'h5;
	localparam ST_QSTOP      = 4'h6;
	localparam ST_FREACT     = 4'h7;
	localparam ST_FAULT      = 4'h8;

	reg [3:0]        state_r;
	reg [3:0]        state_nxt;
	reg              reset_prev_r;
	reg              from_qstop_r;
	reg              from_qstop_nxt;
	reg              cfault_r;
	reg              cfault_nxt;
	reg [WAIT_W-1:0] wait_r;
	reg [WAIT_W-1:0] wait_nxt;
	reg [15:0]       status_nxt;
	wire             fast_bit;
	wire             free_bit;
	wire             rev_bit;

	// compose the status word for a state, used only for the status word register
	function [15:0] status_of;
		input [3:0] st;
		input       qs_flag;
		input       supply;
		reg   [15:0] w;
		begin
			w = `DSCW_STATUS_RESET;
			case (st)
				ST_ON_DIS:   w[`DSCW_SW_ON_DISABLED] = 1'b1;
				ST_READY:    w = 16'h0021;
				ST_SWITCHED: w = 16'h0023;
				ST_ENABLED:  w = 16'h0027;
				ST_QSTOP:    w = 16'h0007;
				ST_FREACT:   w = 16'h000F;
				ST_FAULT:    w = qs_flag ? 16'h0028 : 16'h0008;
				default:     w = 16'h0000;
			endcase
			w[`DSCW_SW_VOLT_PRESENT] = supply & (st != ST_NOT_READY);
			status_of = w;
		end
	endfunction

	// a disabled function selector never matches, so unassigned bits do nothing
	dscw_bit_select u_fast (
		.ctrl_word (ctrl_word),
		.sel       (sel_fast_stop),
		.hit       (fast_bit)
	);
	dscw_bit_select u_free (
		.ctrl_word (ctrl_word),
		.sel       (sel_freewheel),
		.hit       (free_bit)
	);
	dscw_bit_select u_rev (
		.ctrl_word (ctrl_word),
		.sel       (sel_reverse),
		.hit       (rev_bit)
	);

	wire cw_on    = ctrl_word[`DSCW_CW_SWITCH_ON];
	wire cw_volt  = ctrl_word[`DSCW_CW_ENABLE_VOLT];
	wire cw_qs_n  = ctrl_word[`DSCW_CW_QUICK_STOP_N];
	wire cw_enop  = ctrl_word[`DSCW_CW_ENABLE_OP];
	wire cw_halt  = ctrl_word[`DSCW_CW_HALT];
	wire fr_rise  = ctrl_word[`DSCW_CW_FAULT_RESET] & ~reset_prev_r;
	wire fast_req = term_fast_stop | fast_bit;
	wire free_req = term_freewheel | free_bit;
	wire shutdown = cw_volt & cw_qs_n & ~cw_on;
	wire sw_on    = cw_volt & cw_qs_n & cw_on;
	wire powered  = (state_r == ST_ENABLED) | (state_r == ST_QSTOP);

	always @* begin
		state_nxt      = state_r;
		from_qstop_nxt = from_qstop_r;
		cfault_nxt     = cfault_r;
		wait_nxt       = {WAIT_W{1'b0}};
		if (fault_detect && state_r != ST_FREACT && state_r != ST_FAULT &&
			state_r != ST_NOT_READY) begin
			state_nxt      = ST_FREACT;
			from_qstop_nxt = (state_r == ST_QSTOP);
		end else begin
			case (state_r)
				ST_NOT_READY: begin
					if (init_done)
						state_nxt = ST_ON_DIS;
				end
				ST_ON_DIS: begin
					if (shutdown && !free_req)
						state_nxt = ST_READY;
				end
				ST_READY: begin
					if (!cw_volt || free_req)
						state_nxt = ST_ON_DIS;
					else if (sw_on)
						state_nxt = (cw_enop && supply_present) ? ST_ENABLED : ST_SWITCHED;
				end
				ST_SWITCHED: begin
					wait_nxt = wait_r;
					if (!cw_volt || free_req)
						state_nxt = ST_ON_DIS;
					else if (!cw_on || !cw_qs_n)
						state_nxt = ST_READY;
					else if (!supply_present) begin
						if (wait_r >= SUPPLY_WAIT_CYC[WAIT_W-1:0] - 1'b1) begin
							cfault_nxt     = 1'b1;
							state_nxt      = ST_FREACT;
							from_qstop_nxt = 1'b0;
						end else
							wait_nxt = wait_r + 1'b1;
					end else if (cw_enop && !fast_req)
						state_nxt = ST_ENABLED;
				end
				ST_ENABLED: begin
					if (!cw_volt || free_req)
						state_nxt = ST_ON_DIS;
					else if (fast_req)
						state_nxt = ST_SWITCHED;
					else if (!cw_qs_n)
						state_nxt = ST_QSTOP;
					else if (!cw_on)
						state_nxt = ST_READY;
					else if (!cw_enop)
						state_nxt = ST_SWITCHED;
				end
				ST_QSTOP: begin
					if (!cw_volt || free_req || quick_stop_done)
						state_nxt = ST_ON_DIS;
				end
				ST_FREACT: begin
					if (fault_reaction_done)
						state_nxt = ST_FAULT;
				end
				ST_FAULT: begin
					if (fr_rise && !fault_detect) begin
						state_nxt  = ST_ON_DIS;
						cfault_nxt = 1'b0;
					end
				end
				default: state_nxt = ST_NOT_READY;
			endcase
		end
		status_nxt = status_of(state_nxt, from_qstop_nxt, supply_present);
		status_nxt[`DSCW_SW_WARNING]     = warning_active;
		status_nxt[`DSCW_SW_REMOTE]      = fieldbus_source;
		status_nxt[`DSCW_SW_REF_REACHED] = ref_reached;
		status_nxt[`DSCW_SW_REF_LIMIT]   = ref_limit;
		status_nxt[`DSCW_SW_STOP_KEY]    = stop_key;
		// direction bit follows the same edge as reverse_dir, no extra lag
		status_nxt[`DSCW_SW_DIRECTION]   = rev_bit;
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			state_r                 <= ST_NOT_READY;
			reset_prev_r            <= 1'b0;
			from_qstop_r            <= 1'b0;
			cfault_r                <= 1'b0;
			wait_r                  <= {WAIT_W{1'b0}};
			drive_state_report_word <= `DSCW_STATUS_RESET;
			op_state                <= ST_NOT_READY;
			power_enable            <= 1'b0;
			motion_stop             <= 1'b0;
			reverse_dir             <= 1'b0;
			contactor_close         <= 1'b0;
			contactor_fault         <= 1'b0;
			supply_absent_display   <= 1'b0;
		end else begin
			state_r                 <= state_nxt;
			reset_prev_r            <= ctrl_word[`DSCW_CW_FAULT_RESET];
			from_qstop_r            <= from_qstop_nxt;
			cfault_r                <= cfault_nxt;
			wait_r                  <= wait_nxt;
			drive_state_report_word <= status_nxt;
			op_state                <= state_nxt;
			// halt keeps state 5 but removes power and commands the stop
			power_enable            <= (state_nxt == ST_ENABLED || state_nxt == ST_QSTOP) &&
			                           !cw_halt;
			motion_stop             <= (state_nxt == ST_ENABLED) && cw_halt;
			reverse_dir             <= rev_bit;
			// contactor stays closed from switch on until leaving states 4, 5 and 6
			contactor_close         <= contactor_mode &&
			                           (state_nxt == ST_SWITCHED || state_nxt == ST_ENABLED ||
			                            state_nxt == ST_QSTOP);
			contactor_fault         <= cfault_nxt;
			supply_absent_display   <= (state_nxt == ST_READY) && !supply_present;
		end
	end
endmodule

// File: verification/dscw_master.sv
// fieldbus master model: turns a command index into a control word
// assumes cmd changes just after a rising edge; word moves on the next edge
module dscw_master (
	input  logic        clk,
	input  logic [2:0]  cmd,
	input  logic [15:0] extra,
	input  logic [3:0]  op_state,
	output logic [15:0] ctrl_word,
	output logic [15:0] ref_value
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] code;
	initial ctrl_word = 16'h0000;
	always_comb begin
		case (cmd)
		3'h1: code = 16'h0006;
		3'h2: code = 16'h0007;
		3'h3: code = 16'h000F;
		3'h4: code = 16'h0002;
		3'h5: code = 16'h0080;
		default: code = 16'h0000;
		endcase
	end
	// motion reference only once enabled, never while still powering up
	always @(posedge clk) begin
		ctrl_word <= code | extra;
		ref_value <= (op_state == 4'h5) ? 16'h05DC : 16'h0000;
	end
endmodule

// File: verification/dscw_core_properties.sv
// port assertions for the drive state machine
// assumes binding into dscw_core with the same supply wait parameter
module dscw_core_properties #(
	parameter int SUPPLY_WAIT_CYC = 20
) (
	input wire        clk,
	input wire        rst_n,
	input wire [15:0] ctrl_word,
	input wire        supply_present,
	input wire        term_fast_stop,
	input wire        term_freewheel,
	input wire        fault_detect,
	input wire        fieldbus_source,
	input wire [2:0]  sel_reverse,
	input wire [15:0] drive_state_report_word,
	input wire [3:0]  op_state,
	input wire        power_enable,
	input wire        motion_stop,
	input wire        reverse_dir
);
	timeunit 1ns;
	timeprecision 1ps;
	wire [15:0] sw;
	logic [31:0] wait_cnt_r;
	assign sw = drive_state_report_word;
	always @(posedge clk)
		if (!rst_n || op_state != 4'h4 || supply_present) wait_cnt_r <= 32'h0;
		else wait_cnt_r <= wait_cnt_r + 32'h1;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_halt_stays_enabled:
		assert property (motion_stop |-> op_state == 4'h5) else $error("halt left state 5");
	a_halt_no_torque:
		assert property (motion_stop |-> !power_enable) else $error("power on in halt");
	a_fast_stop_switched:
		assert property (op_state == 4'h5 && term_fast_stop && ctrl_word == 16'h000F &&
			!fault_detect && !term_freewheel |=> op_state == 4'h4)
		else $error("fast stop missed state 4");
	a_reverse_follows_bit:
		assert property ($past(rst_n) && $past(sel_reverse) == 3'h1 |->
			reverse_dir == $past(ctrl_word[11])) else $error("direction not from bit 11");
	a_high_bits_copy:
		assert property ($past(rst_n) |-> sw[9] == $past(fieldbus_source) && !sw[8] &&
			sw[13:12] == 2'h0) else $error("high status bits wrong");
	a_status_dir_bit:
		assert property (sw[15] == reverse_dir) else $error("status direction bit wrong");
	a_masked_disabled:
		assert property (op_state == 4'h2 |-> (sw & 16'h006F) == 16'h0040)
		else $error("state 2 masked value wrong");
	a_reaction_bits:
		assert property (op_state == 4'h7 |-> sw[3:0] == 4'hF && !sw[6])
		else $error("fault reaction bits wrong");
	a_ready_supply_code:
		assert property (op_state == 4'h3 && $past(rst_n) |->
			sw[6:0] == ($past(supply_present) ? 7'h31 : 7'h21)) else $error("ready code wrong");
	a_supply_timeout:
		assert property (wait_cnt_r <= SUPPLY_WAIT_CYC + 4) else $error("no supply timeout");
	c_halt: cover property (motion_stop);
	c_quick: cover property (op_state == 4'h6);
	c_fault: cover property (op_state == 4'h8);
endmodule
bind dscw_core dscw_core_properties #(.SUPPLY_WAIT_CYC(SUPPLY_WAIT_CYC)) i_props (
	.clk, .rst_n, .ctrl_word, .supply_present, .term_fast_stop, .term_freewheel, .fault_detect,
	.fieldbus_source, .sel_reverse, .drive_state_report_word, .op_state,
	.power_enable, .motion_stop, .reverse_dir);

// File: verification/drive_state_control_words_test.sv
// self-checking bench for the drive state machine
// assumes a short supply wait; the master model feeds the control word
module drive_state_control_words_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [2:0]  cmd;
		logic        sup;
		logic        qsd;
		logic [3:0]  st;
		logic [15:0] msk;
	} dscw_row_t;
	logic        clk = 0, rst_n = 0, init_done = 0, sup = 0, cmode = 0, tfs = 0;
	logic        fdet = 0, frd = 0, qsd = 0, tfw = 0, pe, ms, rd, cc, cf, sad;
	logic [4:0]  aux = 0;
	logic [2:0]  cmd = 0;
	logic [3:0]  st;
	logic [15:0] extra = 0, ctrl_word, ref_value, sw;
	int          num_errors = 0, tests_run = 0, cyc = 0;
	dscw_row_t   rows [10] = '{'{3'h0, 1'h0, 1'h0, 4'h2, 16'h0040},
		'{3'h1, 1'h0, 1'h0, 4'h3, 16'h0021}, '{3'h3, 1'h1, 1'h0, 4'h5, 16'h0027},
		'{3'h2, 1'h1, 1'h0, 4'h4, 16'h0023}, '{3'h3, 1'h1, 1'h0, 4'h5, 16'h0027},
		'{3'h4, 1'h1, 1'h0, 4'h6, 16'h0007}, '{3'h4, 1'h1, 1'h1, 4'h2, 16'h0040},
		'{3'h1, 1'h1, 1'h0, 4'h3, 16'h0021}, '{3'h2, 1'h1, 1'h0, 4'h4, 16'h0023},
		'{3'h0, 1'h1, 1'h0, 4'h2, 16'h0040}};
	dscw_master i_dscw_master (.clk(clk), .cmd(cmd), .extra(extra), .op_state(st),
		.ctrl_word(ctrl_word), .ref_value(ref_value));
	dscw_core #(.SUPPLY_WAIT_CYC(20)) i_dscw_core (.clk(clk), .rst_n(rst_n),
		.ctrl_word(ctrl_word), .init_done(init_done), .supply_present(sup),
		.contactor_mode(cmode), .sel_fast_stop(3'h4), .sel_freewheel(3'h3),
		.sel_reverse(3'h1), .term_fast_stop(tfs), .term_freewheel(tfw),
		.fault_detect(fdet), .fault_reaction_done(frd), .warning_active(aux[0]),
		.fieldbus_source(aux[1]), .ref_reached(aux[2]), .ref_limit(aux[3]),
		.stop_key(aux[4]), .quick_stop_done(qsd), .drive_state_report_word(sw),
		.op_state(st), .power_enable(pe), .motion_stop(ms), .reverse_dir(rd),
		.contactor_close(cc), .contactor_fault(cf), .supply_absent_display(sad));
	always #4 clk = ~clk;
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic go(input logic [2:0] c, input logic [15:0] x);
		cmd = c;
		extra = x;
		step(3);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ceiling well above the roughly 130 cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			num_errors++;
			tally_and_finish;
		end
	end
	initial begin
		step(16);
		chk({12'h000, st}, 16'h0001);
		chk(sw, 16'h0000);
		rst_n = 1;
		init_done = 1;
		foreach (rows[i]) begin
			sup = rows[i].sup;
			qsd = rows[i].qsd;
			go(rows[i].cmd, 16'h0000);
			chk({12'h000, st}, {12'h000, rows[i].st});
			chk(sw & 16'h006F, rows[i].msk);
		end
		sup = 0;
		go(3'h1, 16'h0000);
		chk({sw[15:1], sad}, 16'h0021);
		sup = 1;
		step(2);
		chk(sw & 16'h00FF, 16'h0031);
		go(3'h3, 16'h0900);
		chk({8'h00, sw[15], pe, ms, rd, st}, 16'h00B5);
		aux = 5'h1F;
		go(3'h3, 16'h0000);
		chk(sw & 16'hFF80, 16'h4E80);
		chk({14'h0000, pe, ms}, 16'h0002);
		chk(ref_value, 16'h05DC);
		tfs = 1;
		step(2);
		chk({12'h000, st}, 16'h0004);
		tfs = 0;
		go(3'h3, 16'h2000);
		chk({12'h000, st}, 16'h0002);
		cmode = 1;
		sup = 0;
		go(3'h1, 16'h0000);
		go(3'h2, 16'h0000);
		chk({11'h000, cc, st}, 16'h0014);
		step(30);
		chk({11'h000, cf, st}, 16'h0017);
		frd = 1;
		cmode = 0;
		sup = 1;
		step(2);
		chk(sw & 16'h006F, 16'h0008);
		go(3'h5, 16'h0000);
		chk({11'h000, cf, st}, 16'h0002);
		go(3'h1, 16'h0000);
		go(3'h3, 16'h0000);
		go(3'h4, 16'h0000);
		fdet = 1;
		step(3);
		chk(sw & 16'h006F, 16'h0028);
		// fast stop through control word bit 14, then freewheel from the terminal
		fdet = 0;
		go(3'h5, 16'h0000);
		go(3'h1, 16'h0000);
		go(3'h3, 16'h4000);
		chk({12'h000, st}, 16'h0004);
		tfw = 1;
		step(2);
		chk({12'h000, st}, 16'h0002);
		tfw = 0;
		// reset in mid-run clears every output except op_state, which returns to 1, then start-up resumes
		rst_n = 0;
		step(2);
		chk({6'h00, pe, ms, rd, cc, cf, sad, st}, 16'h0001);
		chk(sw, 16'h0000);
		rst_n = 1;
		step(2);
		chk({12'h000, st}, 16'h0002);
		chk(sw & 16'h006F, 16'h0040);
		tally_and_finish;
	end
endmodule
